// *** hdl/ddc_pkg.sv ***
package ddc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_FREQ0     = 8'h08;
  localparam logic [7:0] ADDR_PHASE0    = 8'h0C;
  localparam logic [7:0] ADDR_CHCFG0    = 8'h10;
  localparam logic [7:0] ADDR_FREQ1     = 8'h14;
  localparam logic [7:0] ADDR_PHASE1    = 8'h18;
  localparam logic [7:0] ADDR_CHCFG1    = 8'h1C;
  localparam logic [7:0] ADDR_RECLEN    = 8'h20;
  localparam logic [7:0] ADDR_COEF      = 8'h24;
  localparam logic [7:0] ADDR_RECCNT    = 8'h28;
  localparam logic [7:0] ADDR_TSTAMP    = 8'h2C;
  // ctrl fields
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_TRIGMODE = 1;
  localparam int CTRL_ARM      = 2;
  localparam int CTRL_USETRIG  = 3;
  // channel config fields
  localparam int CFG_DEC_LSB   = 0;
  localparam int CFG_DEC_W     = 4;
  localparam int CFG_REALIN    = 4;
  localparam int CFG_FIR_EN    = 5;
  localparam int CFG_FIR_CPLX  = 6;
  localparam int CFG_WIDE      = 7;
  // status fields
  localparam int STAT_PEND     = 0;
  localparam int STAT_ACTIVE   = 1;
  localparam int STAT_FIR0_OK  = 2;
  localparam int STAT_FIR1_OK  = 3;
  // decimation stage count
  localparam int NSTAGE        = 8;
  localparam logic [3:0] WIDE_MIN_DEC = 4'd9;
  // least stage count whose output may feed the general filter: 3 half-band stages
  localparam logic [3:0] FIR_MIN_DEC  = 4'd3;
  localparam int NTAP          = 4;
  localparam int SW            = 16;
  localparam logic [31:0] RECLEN_RST = 32'h0000_0400;
  localparam logic [15:0] HDR_MARK   = 16'hA5A5;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b10,
    ST_WAIT = 2'b11
  } acq_e;
endpackage : ddc_pkg

// *** hdl/dual_digital_down_converter.sv ***
`timescale 1ns/1ps
module dual_digital_down_converter
  import ddc_pkg::*;
(
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // converter samples, one per clock, same domain
  input  wire logic [SW-1:0]     adc_a,
  input  wire logic [SW-1:0]     adc_b,
  // external pins
  input  wire logic              sync_pin,
  input  wire logic              trig_pin,
  input  wire logic              ref_10m_tick,
  // stream towards the off-block fifo
  output logic      [63:0]       out_data,
  output logic                   out_valid,
  output logic                   out_header,
  input  wire logic              out_ready
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl;
  logic [31:0] freq   [2];
  logic [31:0] phase  [2];
  logic [7:0]  chcfg  [2];
  logic [31:0] reclen;
  logic signed [SW-1:0] coef [NTAP];
  logic [31:0] rec_num;
  logic [31:0] tstamp;
  logic        lock_pend;
  acq_e        acq;
  // trigger time is frozen so a stalled header does not drift
  logic [31:0] trig_ts;
  wire         hdr_take = out_valid & out_header & out_ready;

  function automatic logic fir_allowed(input logic [7:0] c);
    fir_allowed = c[CFG_DEC_LSB +: CFG_DEC_W] >= FIR_MIN_DEC;
  endfunction : fir_allowed

  // input pins pass two flops
  logic [1:0] sync_s, trig_s, ref_s;
  logic       sync_d, trig_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_s <= 2'b00;
      trig_s <= 2'b00;
      ref_s  <= 2'b00;
      sync_d <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      sync_s <= {sync_s[0], sync_pin};
      trig_s <= {trig_s[0], trig_pin};
      ref_s  <= {ref_s[0], ref_10m_tick};
      sync_d <= sync_s[1];
      trig_d <= trig_s[1];
    end
  end
  wire sync_ev  = sync_s[1] & ~sync_d;
  wire trig_ev  = trig_s[1] & ~trig_d;
  wire align_ev = ctrl[CTRL_USETRIG] ? trig_ev : sync_ev;
  // lock lands on the first cycle the synchronised reference is high after the alignment pulse
  logic lock_wait;
  wire  lock_now = lock_wait & ref_s[1];

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait state
  wire wr = psel & penable & pwrite;
  assign pready  = 1'b1;
  logic bad_addr;
  always_comb begin
    bad_addr = 1'b0;
    if (paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_FREQ0 ||
        paddr == ADDR_PHASE0 || paddr == ADDR_CHCFG0 || paddr == ADDR_FREQ1 ||
        paddr == ADDR_PHASE1 || paddr == ADDR_CHCFG1 || paddr == ADDR_RECLEN ||
        paddr == ADDR_COEF || paddr == ADDR_RECCNT || paddr == ADDR_TSTAMP) begin
      bad_addr = 1'b0;
    end else begin
      bad_addr = 1'b1;
    end
  end
  assign pslverr = psel & penable & bad_addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= 32'h0000_0000;
      freq[0]  <= 32'h0000_0000;
      freq[1]  <= 32'h0000_0000;
      phase[0] <= 32'h0000_0000;
      phase[1] <= 32'h0000_0000;
      chcfg[0] <= 8'h00;
      chcfg[1] <= 8'h00;
      reclen   <= RECLEN_RST;
      for (int i = 0; i < NTAP; i++) begin
        coef[i] <= '0;
      end
    end else begin
      if (lock_now) begin
        ctrl[CTRL_ARM] <= 1'b0;
      end
      if (wr) begin
        if (paddr == ADDR_CTRL) begin
          ctrl <= {28'h0000000, pwdata[3:0]};
        end else if (paddr == ADDR_FREQ0) begin
          freq[0] <= pwdata;
        end else if (paddr == ADDR_PHASE0) begin
          phase[0] <= pwdata;
        end else if (paddr == ADDR_CHCFG0) begin
          chcfg[0] <= pwdata[7:0];
        end else if (paddr == ADDR_FREQ1) begin
          freq[1] <= pwdata;
        end else if (paddr == ADDR_PHASE1) begin
          phase[1] <= pwdata;
        end else if (paddr == ADDR_CHCFG1) begin
          chcfg[1] <= pwdata[7:0];
        end else if (paddr == ADDR_RECLEN) begin
          reclen <= pwdata;
        end else if (paddr == ADDR_COEF) begin
          // shift-in loader keeps the map small
          coef[0] <= pwdata[SW-1:0];
          for (int i = 1; i < NTAP; i++) begin
            coef[i] <= coef[i-1];
          end
        end
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      prdata = ctrl;
    end else if (paddr == ADDR_STATUS) begin
      prdata = {28'h0000000, fir_allowed(chcfg[1]), fir_allowed(chcfg[0]),
                acq != ST_IDLE, lock_pend};
    end else if (paddr == ADDR_FREQ0) begin
      prdata = freq[0];
    end else if (paddr == ADDR_PHASE0) begin
      prdata = phase[0];
    end else if (paddr == ADDR_CHCFG0) begin
      prdata = {24'h000000, chcfg[0]};
    end else if (paddr == ADDR_FREQ1) begin
      prdata = freq[1];
    end else if (paddr == ADDR_PHASE1) begin
      prdata = phase[1];
    end else if (paddr == ADDR_CHCFG1) begin
      prdata = {24'h000000, chcfg[1]};
    end else if (paddr == ADDR_RECLEN) begin
      prdata = reclen;
    end else if (paddr == ADDR_RECCNT) begin
      prdata = rec_num;
    end else if (paddr == ADDR_TSTAMP) begin
      prdata = tstamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock sequencing and timestamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_wait <= 1'b0;
      lock_pend <= 1'b0;
    end else begin
      lock_pend <= ctrl[CTRL_ARM];
      if (lock_now) begin
        lock_wait <= 1'b0;
      end else if (ctrl[CTRL_ARM] && align_ev) begin
        lock_wait <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstamp <= 32'h0000_0000;
    end else if (ctrl[CTRL_ARM] && align_ev) begin
      tstamp <= 32'h0000_0000;
    end else begin
      tstamp <= tstamp + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two channels
  logic [31:0] ch_i [2];
  logic [31:0] ch_q [2];
  logic        ch_v [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [31:0] acc;
    logic signed [SW-1:0] lo_c, lo_s, mi, mq;
    logic signed [SW-1:0] si [NSTAGE+1];
    logic signed [SW-1:0] sq [NSTAGE+1];
    logic                 sv [NSTAGE+1];
    wire  [3:0] ndec = chcfg[c][CFG_DEC_LSB +: CFG_DEC_W];
    wire  signed [SW-1:0] in_i = (c == 0) ? adc_a : adc_b;
    wire  signed [SW-1:0] in_q = chcfg[c][CFG_REALIN] ? '0 : ((c == 0) ? adc_b : adc_a);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc <= 32'h0000_0000;
      end else if (lock_now) begin
        acc <= phase[c];
      end else begin
        acc <= acc + freq[c];
      end
    end

    // coarse quarter-wave oscillator: phase picks sign and axis
    always_comb begin
      lo_c = '0;
      lo_s = '0;
      case (acc[31:30])
        2'b00: begin lo_c = 16'sh7FFF; lo_s = 16'sh0000; end
        2'b01: begin lo_c = 16'sh0000; lo_s = 16'sh7FFF; end
        2'b10: begin lo_c = -16'sh7FFF; lo_s = 16'sh0000; end
        default: begin lo_c = 16'sh0000; lo_s = -16'sh7FFF; end
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mi <= '0;
        mq <= '0;
      end else begin
        // complex product; real input has zero q
        mi <= SW'((32'(in_i * lo_c) + 32'(in_q * lo_s)) >>> 15);
        mq <= SW'((32'(in_q * lo_c) - 32'(in_i * lo_s)) >>> 15);
      end
    end

    assign si[0] = mi;
    assign sq[0] = mq;
    assign sv[0] = 1'b1;

    // identical half-band stages [1 2 1]/4 (coarse, ~40% pass band)
    for (genvar s = 0; s < NSTAGE; s++) begin : g_hb
      logic signed [SW-1:0] di1, di2, dq1, dq2, oi, oq;
      logic ph, ov;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          di1 <= '0; di2 <= '0; dq1 <= '0; dq2 <= '0;
          oi <= '0; oq <= '0; ph <= 1'b0; ov <= 1'b0;
        end else begin
          ov <= 1'b0;
          if (sv[s]) begin
            di1 <= si[s];
            di2 <= di1;
            dq1 <= sq[s];
            dq2 <= dq1;
            ph  <= ~ph;
            if (ph) begin
              oi <= SW'((18'(si[s]) + (18'(di1) <<< 1) + 18'(di2)) >>> 2);
              oq <= SW'((18'(sq[s]) + (18'(dq1) <<< 1) + 18'(dq2)) >>> 2);
              ov <= 1'b1;
            end
          end
        end
      end
      assign si[s+1] = oi;
      assign sq[s+1] = oq;
      assign sv[s+1] = ov;
    end

    // tap chosen by stage count; zero or a count above 8 means bypass
    logic signed [SW-1:0] di, dq;
    logic                 dv;
    always_comb begin
      di = si[0];
      dq = sq[0];
      dv = sv[0];
      for (int k = 1; k <= NSTAGE; k++) begin
        if (ndec == 4'(k)) begin
          di = si[k];
          dq = sq[k];
          dv = sv[k];
        end
      end
    end

    // general filter, shift line
    logic signed [SW-1:0] li [NTAP];
    logic signed [SW-1:0] lq [NTAP];
    logic signed [SW+7:0] yi, yq, ri, rq;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int t = 0; t < NTAP; t++) begin
          li[t] <= '0;
          lq[t] <= '0;
        end
      end else if (dv) begin
        li[0] <= di;
        lq[0] <= dq;
        for (int t = 1; t < NTAP; t++) begin
          li[t] <= li[t-1];
          lq[t] <= lq[t-1];
        end
      end
    end
    always_comb begin
      ri = '0;
      rq = '0;
      for (int t = 0; t < NTAP; t++) begin
        ri = ri + (SW+8)'((32'(li[t] * coef[t])) >>> 15);
        rq = rq + (SW+8)'((32'(lq[t] * coef[t])) >>> 15);
      end
      // complex mode: newest sample of the other branch times the last coefficient adds the imaginary part
      yi = ri;
      yq = rq;
      if (chcfg[c][CFG_FIR_CPLX]) begin
        yi = ri - (SW+8)'((32'(lq[0] * coef[NTAP-1])) >>> 15);
        yq = rq + (SW+8)'((32'(li[0] * coef[NTAP-1])) >>> 15);
      end
    end

    wire use_fir = chcfg[c][CFG_FIR_EN] & fir_allowed(chcfg[c]);
    wire wide    = chcfg[c][CFG_WIDE] & (ndec >= WIDE_MIN_DEC);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_i[c] <= 32'h0000_0000;
        ch_q[c] <= 32'h0000_0000;
        ch_v[c] <= 1'b0;
      end else begin
        ch_v[c] <= dv;
        if (use_fir) begin
          ch_i[c] <= 32'(signed'(yi[SW-1:0]));
          ch_q[c] <= 32'(signed'(yq[SW-1:0]));
        end else if (wide) begin
          ch_i[c] <= {di, 16'h0000};
          ch_q[c] <= {dq, 16'h0000};
        end else begin
          ch_i[c] <= 32'(signed'(di));
          ch_q[c] <= 32'(signed'(dq));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // record streaming; channel 0 paces the stream
  logic [31:0] left;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq     <= ST_IDLE;
      left    <= 32'h0000_0000;
      trig_ts <= 32'h0000_0000;
      rec_num <= 32'h0000_0000;
    end else begin
      case (acq)
        ST_IDLE: begin
          // triggers are dropped while armed/locking
          if (ctrl[CTRL_RUN] && !ctrl[CTRL_ARM] && !lock_wait && trig_ev) begin
            acq <= ctrl[CTRL_TRIGMODE] ? ST_HDR : ST_DATA;
            left <= reclen;
            trig_ts <= tstamp;
          end
        end
        ST_HDR: begin
          if (hdr_take) begin
            acq <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (!ctrl[CTRL_RUN]) begin
            acq <= ST_IDLE;
          end else if (ctrl[CTRL_TRIGMODE] && ch_v[0] && out_ready) begin
            left <= left - 32'd1;
            if (left == 32'd1) begin
              rec_num <= rec_num + 32'd1;
              acq <= ST_WAIT;
            end
          end
        end
        default: begin
          acq <= ST_IDLE;
        end
      endcase
    end
  end

  // output data from flops; stall sheds samples, fifo is off-block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data   <= 64'h0;
      out_valid  <= 1'b0;
      out_header <= 1'b0;
    end else begin
      out_valid  <= 1'b0;
      out_header <= 1'b0;
      // header stands until the sink takes it; a taken header is not repeated
      if (acq == ST_HDR && !hdr_take) begin
        out_data   <= {HDR_MARK, rec_num[15:0], trig_ts};
        out_valid  <= 1'b1;
        out_header <= 1'b1;
      end else if (acq == ST_DATA && ch_v[0]) begin
        // two bytes per branch sample, eight per channel pair
        out_data  <= {ch_q[1][SW-1:0], ch_i[1][SW-1:0],
                      ch_q[0][SW-1:0], ch_i[0][SW-1:0]};
        out_valid <= 1'b1;
      end
    end
  end
endmodule : dual_digital_down_converter

// *** sim/ddc_properties.sv ***
`timescale 1ns/1ps
module ddc_properties
  import ddc_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // stream
  input wire logic [63:0] out_data,
  input wire logic        out_valid,
  input wire logic        out_header,
  input wire logic        out_ready
);
  logic        acc;
  logic        bad;
  logic        hdr_ok;
  logic        tmode;
  logic        seen;
  logic [31:0] rlen;
  logic [31:0] dcnt;
  logic [15:0] last_rec;
  assign acc    = psel && penable;
  assign bad    = paddr > ADDR_TSTAMP || paddr[1:0] != 2'b00;
  assign hdr_ok = out_valid && out_header && out_ready;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the written record setup, so the checker needs no peeking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlen  <= RECLEN_RST;
      tmode <= 1'b0;
    end else if (acc && pwrite && pready && paddr == ADDR_RECLEN) begin
      rlen <= pwdata;
    end else if (acc && pwrite && pready && paddr == ADDR_CTRL) begin
      tmode <= pwdata[CTRL_TRIGMODE];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt     <= 32'h0000_0000;
      seen     <= 1'b0;
      last_rec <= 16'h0000;
    end else if (hdr_ok) begin
      dcnt     <= 32'h0000_0000;
      seen     <= 1'b1;
      last_rec <= out_data[47:32];
    end else if (out_valid && !out_header) begin
      dcnt <= dcnt + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_err_unmapped: assert property (acc && bad |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  chk_hdr_valid: assert property (out_header |-> out_valid)
    else $error("header flag without valid");
  chk_hdr_mark: assert property (out_valid && out_header |-> out_data[63:48] == HDR_MARK)
    else $error("header mark wrong");
  chk_hdr_hold: assert property (out_valid && out_header && !out_ready |=> out_valid && out_header && $stable(out_data))
    else $error("header dropped while stalled");
  chk_rec_step: assert property (hdr_ok && seen |-> out_data[47:32] == last_rec + 16'h0001)
    else $error("record number not sequential");
  chk_rec_len: assert property (tmode |-> dcnt <= rlen)
    else $error("record longer than set length");
  chk_data_after_hdr: assert property (tmode && out_valid && !out_header |-> seen)
    else $error("record data without header");
  chk_reset_quiet: assert property (disable iff (1'b0) !presetn |-> !out_valid && pready)
    else $error("outputs active in reset");
  cov_header: cover property (hdr_ok);
  cov_unmapped: cover property (acc && bad);
  cov_data: cover property (out_valid && !out_header);
endmodule : ddc_properties

bind dual_digital_down_converter ddc_properties ddc_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .out_data(out_data), .out_valid(out_valid), .out_header(out_header), .out_ready(out_ready)
);

// *** sim/stream_sink.sv ***
`timescale 1ns/1ps
module stream_sink (
  // clock
  input  wire logic pclk,
  input  wire logic presetn,
  // stream
  input  wire logic out_valid,
  input  wire logic out_header,
  output logic      out_ready
);
  logic [2:0] st;
  // stalls every header for four cycles; data always taken, since the
  // block drops data words that meet a stall
  assign out_ready = (st == 3'd4) || !(out_valid && out_header);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= 3'd0;
    end else if (st == 3'd4 && !out_header) begin
      st <= 3'd0;
    end else if (st != 3'd4 && out_valid && out_header) begin
      st <= st + 3'd1;
    end
  end
endmodule : stream_sink

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import ddc_pkg::*;
;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} rd_s;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] adc_a;
  logic [15:0] adc_b;
  logic        sync_pin;
  logic        trig_pin;
  logic        ref_10m_tick;
  logic [63:0] out_data;
  logic        out_valid;
  logic        out_header;
  logic        out_ready;
  logic [31:0] rnd;
  logic [2:0]  refc;
  logic [31:0] vals [4];
  logic [7:0]  regs [4];
  rd_s         rq [$];
  logic        sq [$];
  logic        cont;
  int          vcnt;
  int          hdrs;
  int          error_cnt;
  int          tests_run;
  dual_digital_down_converter dual_digital_down_converter_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_a(adc_a), .adc_b(adc_b), .sync_pin(sync_pin), .trig_pin(trig_pin),
    .ref_10m_tick(ref_10m_tick), .out_data(out_data), .out_valid(out_valid),
    .out_header(out_header), .out_ready(out_ready));
  stream_sink stream_sink_i (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
    .out_header(out_header), .out_ready(out_ready));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask : cmp
  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    if (!wr) rq.push_back('{d, m, e});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wr ? d : rnd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pin_pulse(input logic s);
    @(posedge pclk);
    if (s) sync_pin <= 1'b1;
    else trig_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    sync_pin <= 1'b0;
    trig_pin <= 1'b0;
  endtask : pin_pulse
  task automatic record();
    sq.push_back(1'b1);
    repeat (4) sq.push_back(1'b0);
    pin_pulse(1'b0);
    for (int i = 0; i < 200 && sq.size() != 0; i++) @(posedge pclk);
    cmp(32'(sq.size()), 32'h0, 32'hFFFF_FFFF);
  endtask : record
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // random samples and a 10 MHz reference level, changed on the edge
  always @(posedge pclk) begin
    rnd          <= lfsr_next(rnd);
    adc_a        <= rnd[15:0];
    adc_b        <= rnd[31:16];
    refc         <= (refc == 3'd4) ? 3'd0 : refc + 3'd1;
    ref_10m_tick <= refc < 3'd2;
  end
  // results are judged at the edge they are sampled on
  always @(posedge pclk) begin
    rd_s r;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      r = rq.pop_front();
      cmp(prdata, r.d, r.m);
      cmp({31'h0, pslverr}, {31'h0, r.e}, 32'h0000_0001);
    end
    if (presetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (cont) begin
        cmp({31'h0, out_header}, 32'h0, 32'h1);
        vcnt++;
      end else if (sq.size() == 0) begin
        cmp(32'h1, 32'h0, 32'h1);
      end else begin
        cmp({31'h0, out_header}, {31'h0, sq[0]}, 32'h1);
        if (sq.pop_front()) begin
          cmp({16'h0, out_data[63:48]}, {16'h0, HDR_MARK}, 32'hFFFF);
          cmp({16'h0, out_data[47:32]}, hdrs, 32'hFFFF);
          hdrs++;
        end
      end
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sync_pin, trig_pin} = '0;
    {adc_a, adc_b, ref_10m_tick, refc, cont, vcnt, hdrs, error_cnt, tests_run} = '0;
    rnd     = 32'h0001_62F4;
    regs    = '{ADDR_FREQ0, ADDR_PHASE0, ADDR_FREQ1, ADDR_PHASE1};
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_RECLEN, RECLEN_RST, 32'hFFFF_FFFF, 0);
    apb(0, ADDR_CTRL, 32'h0, 32'hFFFF_FFFF, 0);
    apb(1, 8'h30, 32'h1234_5678, 32'h0, 0);
    apb(0, 8'h30, 32'h0, 32'hFFFF_FFFF, 1);
    // all four written before any read, so crosstalk between channels shows
    for (int i = 0; i < 4; i++) begin
      vals[i] = rnd;
      apb(1, regs[i], vals[i], 32'h0, 0);
    end
    for (int i = 0; i < 4; i++) apb(0, regs[i], vals[i], 32'hFFFF_FFFF, 0);
    apb(1, ADDR_CHCFG0, 32'h73, 32'h0, 0);
    apb(1, ADDR_CHCFG1, 32'h02, 32'h0, 0);
    apb(0, ADDR_CHCFG0, 32'h73, 32'hFF, 0);
    apb(0, ADDR_CHCFG1, 32'h02, 32'hFF, 0);
    apb(0, ADDR_STATUS, 32'h4, 32'hC, 0);
    apb(1, ADDR_CHCFG0, 32'h0, 32'h0, 0);
    apb(1, ADDR_RECLEN, 32'h4, 32'h0, 0);
    repeat (300) @(posedge pclk);
    apb(1, ADDR_CTRL, 32'h7, 32'h0, 0);
    apb(0, ADDR_STATUS, 32'h1, 32'h1, 0);
    pin_pulse(1'b0);
    repeat (20) @(posedge pclk);
    pin_pulse(1'b1);
    apb(0, ADDR_TSTAMP, 32'h0, 32'hFFFF_FF00, 0);
    repeat (20) @(posedge pclk);
    apb(0, ADDR_CTRL, 32'h3, 32'hF, 0);
    record();
    apb(1, ADDR_CTRL, 32'h2, 32'h0, 0);
    apb(1, ADDR_CTRL, 32'hF, 32'h0, 0);
    pin_pulse(1'b0);
    repeat (20) @(posedge pclk);
    apb(0, ADDR_CTRL, 32'hB, 32'hF, 0);
    record();
    apb(1, ADDR_CTRL, 32'h1, 32'h0, 0);
    cont = 1'b1;
    pin_pulse(1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1, ADDR_CHCFG0, k, 32'h0, 0);
      repeat (40) @(posedge pclk);
      // counted between falling edges, clear of the monitor's edge
      @(negedge pclk);
      vcnt = 0;
      repeat (64) @(negedge pclk);
      cmp(vcnt, 32'd64 >> k, 32'hFFFF_FFFF);
    end
    apb(1, ADDR_CTRL, 32'h0, 32'h0, 0);
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    vcnt = 0;
    repeat (30) @(negedge pclk);
    cmp(vcnt, 32'h0, 32'hFFFF_FFFF);
    cont = 1'b0;
    complete_run();
  end
endmodule : tb_top
